// ===== verilog/ffs_supervisor.sv
// fault detection, flag latching and output release for the h-bridge
`timescale 1ns/1ps
module ffs_supervisor
  import ffs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic sleep_mode,
  input wire logic normal_mode,
  input wire logic temp_hot,
  input wire logic temp_warm,
  input wire logic current_high,
  input wire logic load_open,
  input wire logic ol_request,
  input wire logic out1_gnd_short,
  input wire logic out2_gnd_short,
  input wire logic out1_supply_short,
  input wire logic out2_supply_short,
  input wire logic supply_high,
  input wire logic supply_low,
  input wire logic pump_low,
  input wire logic frame_bad,
  input wire logic frame_good,
  input wire logic [CB_W-1:0] clear_bits,
  input wire logic fault_clear,
  input wire logic output_off_pin,
  input wire logic wake_pin,
  output logic overtemp_flag,
  output logic temp_warning_flag,
  output logic overcurrent_flag,
  output logic open_load_flag,
  output logic out1_gnd_short_flag,
  output logic out2_gnd_short_flag,
  output logic out1_supply_short_flag,
  output logic out2_supply_short_flag,
  output logic supply_high_flag,
  output logic supply_low_flag,
  output logic pump_low_flag,
  output logic link_error_flag,
  output logic outputs_off,
  output logic freewheel_high,
  output logic fault_pin_n,
  output logic osc_tick
);
  typedef struct packed {
    logic [7:0] div;
    logic [1:0] spread;
    logic tick;
    logic [CB_W-1:0] flags;
    logic latch_off;
    logic pin_fault;
    logic link_hold;
    logic normal_d;
    logic off_d;
    logic wake_d;
  } ffs_state_type;
  ffs_state_type st_ff;
  ffs_state_type nxt_st;
  logic hot_f;
  logic pump_f;
  logic ov_f;
  logic awake;
  logic [CB_W-1:0] set_v;
  logic [7:0] div_top;
  assign awake = !sleep_mode;
  // divider length wobbles around nominal to spread the tick spectrum
  always_comb
  begin
    div_top = 8'(TICK_DIV - 2) + {6'h00, st_ff.spread};
  end
  ffs_filter #(.LEN((OT_FILT_CYC + TICK_DIV - 1) / TICK_DIV)) u_ot
  (
    .clk(clk),
    .rst(rst),
    .tick(st_ff.tick),
    .cond(temp_hot && normal_mode),
    .hit(hot_f)
  );
  ffs_filter #(.LEN((PUMP_FILT_CYC + TICK_DIV - 1) / TICK_DIV + 1)) u_cp
  (
    .clk(clk),
    .rst(rst),
    .tick(st_ff.tick),
    .cond(pump_low && awake),
    .hit(pump_f)
  );
  ffs_filter #(.LEN(OV_FILT_CYC / TICK_DIV)) u_ov
  (
    .clk(clk),
    .rst(rst),
    .tick(st_ff.tick),
    .cond(supply_high && awake),
    .hit(ov_f)
  );
  always_comb
  begin
    set_v = '0;
    set_v[CB_OT] = hot_f;
    set_v[CB_OC] = current_high && normal_mode;
    set_v[CB_OL] = load_open && ((normal_mode && !st_ff.normal_d) || ol_request);
    set_v[CB_SG1] = out1_gnd_short && normal_mode;
    set_v[CB_SG2] = out2_gnd_short && normal_mode;
    set_v[CB_SP1] = out1_supply_short && normal_mode;
    set_v[CB_SP2] = out2_supply_short && normal_mode;
    set_v[CB_OV] = ov_f;
    set_v[CB_UV] = supply_low && awake;
    set_v[CB_LNK] = frame_bad && awake;
  end
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.normal_d = normal_mode;
    nxt_st.off_d = output_off_pin;
    nxt_st.wake_d = wake_pin;
    nxt_st.tick = 1'b0;
    if (st_ff.div >= div_top)
    begin
      nxt_st.div = 8'h00;
      nxt_st.tick = 1'b1;
      nxt_st.spread = st_ff.spread + 2'h1;
    end
    else
      nxt_st.div = st_ff.div + 8'h01;
    // set wins over a clear in the same cycle
    nxt_st.flags = (st_ff.flags & ~clear_bits) | set_v;
    if (st_ff.link_hold && frame_good)
      nxt_st.link_hold = 1'b0;
    if (set_v[CB_LNK])
      nxt_st.link_hold = 1'b1;
    if (fault_clear || (output_off_pin != st_ff.off_d) || (wake_pin != st_ff.wake_d))
      nxt_st.latch_off = 1'b0;
    if (set_v[CB_OT] || (|set_v[CB_SP2:CB_SG1]))
      nxt_st.latch_off = 1'b1;
    if (fault_clear)
      nxt_st.pin_fault = 1'b0;
    if (|set_v[CB_UV:CB_OV] || nxt_st.latch_off || output_off_pin)
      nxt_st.pin_fault = 1'b1;
  end
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_ff <= '0;
      // pin history follows the pins so release brings no false toggle
      st_ff.off_d <= output_off_pin;
      st_ff.wake_d <= wake_pin;
    end
    else
      st_ff <= nxt_st;
  end
  // warning and pump flags track their condition without latching
  assign temp_warning_flag = temp_warm && awake;
  assign pump_low_flag = pump_f;
  assign overtemp_flag = st_ff.flags[CB_OT];
  assign overcurrent_flag = st_ff.flags[CB_OC];
  assign open_load_flag = st_ff.flags[CB_OL];
  assign out1_gnd_short_flag = st_ff.flags[CB_SG1];
  assign out2_gnd_short_flag = st_ff.flags[CB_SG2];
  assign out1_supply_short_flag = st_ff.flags[CB_SP1];
  assign out2_supply_short_flag = st_ff.flags[CB_SP2];
  assign supply_high_flag = st_ff.flags[CB_OV];
  assign supply_low_flag = st_ff.flags[CB_UV];
  assign link_error_flag = st_ff.flags[CB_LNK];
  // uv and ov act on the live condition so recovery is automatic
  assign outputs_off = st_ff.latch_off || (supply_low && awake) || st_ff.link_hold;
  assign freewheel_high = ov_f && !outputs_off;
  assign fault_pin_n = !st_ff.pin_fault;
  assign osc_tick = st_ff.tick;

  a_ot_latch: assert property (@(posedge clk) disable iff (rst)
    hot_f |=> overtemp_flag && outputs_off) else $error("ot not latched");
  a_ot_hold: assert property (@(posedge clk) disable iff (rst)
    overtemp_flag && !clear_bits[CB_OT] |=> overtemp_flag) else $error("ot lost");
  a_tw_track: assert property (@(posedge clk) disable iff (rst)
    temp_warning_flag == (temp_warm && !sleep_mode)) else $error("tw wrong");
  a_oc_set: assert property (@(posedge clk) disable iff (rst)
    current_high && normal_mode |=> overcurrent_flag) else $error("oc not set");
  a_oc_clear: assert property (@(posedge clk) disable iff (rst)
    overcurrent_flag && clear_bits[CB_OC] && !(current_high && normal_mode)
    |=> !overcurrent_flag) else $error("oc not cleared");
  a_ol_req: assert property (@(posedge clk) disable iff (rst)
    load_open && ol_request |=> open_load_flag) else $error("ol missed");
  a_sg1_off: assert property (@(posedge clk) disable iff (rst)
    out1_gnd_short && normal_mode |=> out1_gnd_short_flag && outputs_off)
    else $error("short not latched");
  a_sp2_off: assert property (@(posedge clk) disable iff (rst)
    out2_supply_short && normal_mode |=> out2_supply_short_flag && outputs_off)
    else $error("short not latched");
  a_uv_off: assert property (@(posedge clk) disable iff (rst)
    supply_low && !sleep_mode |-> outputs_off ##1 supply_low_flag)
    else $error("uv no action");
  sequence s_pump_steady;
    (pump_low && !sleep_mode) [*8];
  endsequence
  a_cp_filter: assert property (@(posedge clk) disable iff (rst)
    $rose(pump_low_flag) |-> $past(pump_low && !sleep_mode)) else $error("pump early");
  a_cp_drop: assert property (@(posedge clk) disable iff (rst)
    !pump_low |=> !pump_low_flag) else $error("pump stuck");
  a_cp_short: assert property (@(posedge clk) disable iff (rst)
    $rose(pump_low) ##0 s_pump_steady |-> !pump_low_flag) else $error("pump no filter");
  a_lnk_set: assert property (@(posedge clk) disable iff (rst)
    frame_bad && !sleep_mode |=> link_error_flag) else $error("frm missed");
  a_tick_gap: assert property (@(posedge clk) disable iff (rst)
    osc_tick |=> !osc_tick [*3]) else $error("tick too fast");
  a_tick_due: assert property (@(posedge clk) disable iff (rst)
    osc_tick |-> ##[4:8] osc_tick) else $error("tick late");
  a_clr_rel: assert property (@(posedge clk) disable iff (rst)
    fault_clear && !set_v[CB_OT] && !(|set_v[CB_SP2:CB_SG1]) |=> !st_ff.latch_off)
    else $error("no release");
  a_pin_hold: assert property (@(posedge clk) disable iff (rst)
    !fault_pin_n && !fault_clear |=> !fault_pin_n) else $error("pin released");
endmodule

// ===== pkg/ffs_pkg.sv
// constants for the fault flag supervisor
package ffs_pkg;
  localparam int CLK_MHZ = 50;
  // filter times in ns, as printed
  localparam int PUMP_FILT_NS = 18000;
  localparam int OT_FILT_NS = 11000;
  localparam int OV_FILT_NS = 3000;
  // pump filter is a least time: round up
  localparam int PUMP_FILT_CYC = (PUMP_FILT_NS * CLK_MHZ + 999) / 1000;
  // ot and ov filters are longest times: round down
  localparam int OT_FILT_CYC = (OT_FILT_NS * CLK_MHZ) / 1000;
  localparam int OV_FILT_CYC = (OV_FILT_NS * CLK_MHZ) / 1000;
  localparam int OSC_KHZ = 9300;
  // shared tick divider, about 9.3 MHz from 50 MHz
  localparam int TICK_DIV = (CLK_MHZ * 1000) / OSC_KHZ;
  localparam int SPREAD_LEN = 4;
  localparam int FILT_W = 10;
  // clear-fault bit positions
  localparam int CB_OT = 0;
  localparam int CB_OC = 1;
  localparam int CB_OL = 2;
  localparam int CB_SG1 = 3;
  localparam int CB_SG2 = 4;
  localparam int CB_SP1 = 5;
  localparam int CB_SP2 = 6;
  localparam int CB_OV = 7;
  localparam int CB_UV = 8;
  localparam int CB_LNK = 9;
  localparam int CB_W = 10;
endpackage

// ===== verilog/ffs_filter.sv
// persistence filter counting shared oscillator ticks
`timescale 1ns/1ps
module ffs_filter
  import ffs_pkg::*;
#(
  parameter int LEN = 4
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic cond,
  output logic hit
);
  typedef struct packed {
    logic [FILT_W-1:0] cnt;
    logic hit;
  } ffs_filt_type;
  ffs_filt_type st_ff;
  ffs_filt_type nxt_st;
  always_comb
  begin
    nxt_st = st_ff;
    if (!cond)
    begin
      nxt_st.cnt = '0;
      nxt_st.hit = 1'b0;
    end
    else if (tick && !st_ff.hit)
    begin
      if (st_ff.cnt >= FILT_W'(LEN - 1))
        nxt_st.hit = 1'b1;
      else
        nxt_st.cnt = st_ff.cnt + 1'b1;
    end
  end
  always_ff @(posedge clk)
  begin
    if (rst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end
  assign hit = st_ff.hit;
endmodule

// ===== sim/ffs_host_model.sv
// host side model that clears flags and restarts the link
`timescale 1ns/1ps
module ffs_host_model
  import ffs_pkg::*;
(
  input wire logic clk,
  output logic [CB_W-1:0] clear_bits,
  output logic fault_clear,
  output logic frame_good
);
  initial
  begin
    clear_bits = 10'h000;
    fault_clear = 1'h0;
    frame_good = 1'h0;
  end
  // one-cycle write of clear bits, clear command and a valid frame
  task automatic clear(input logic [CB_W-1:0] bits);
    clear_bits <= bits;
    fault_clear <= 1'h1;
    frame_good <= 1'h1;
    @(posedge clk);
    clear_bits <= 10'h000;
    fault_clear <= 1'h0;
    frame_good <= 1'h0;
  endtask
endmodule

// ===== sim/tb.sv
// self-checking bench for the fault flag supervisor
`timescale 1ns/1ps
module tb;
  import ffs_pkg::*;
  logic clk = 1'h0, rst = 1'h1, slp = 1'h0, nrm = 1'h0, hot = 1'h0, warm = 1'h0;
  logic cur = 1'h0, lop = 1'h0, shi = 1'h0, slo = 1'h0, pmp = 1'h0, bad = 1'h0;
  logic off_pin = 1'h0, wake = 1'h1, olr = 1'h0;
  int nt0 = 0;
  logic [3:0] sc = 4'h0;
  logic [CB_W-1:0] cb;
  logic fc, fg, off, fwh, fpn, tick;
  logic [11:0] fl;
  int error_cnt = 0, n_tests = 0, nt = 0;
  always #10 clk = ~clk;
  always @(posedge clk) nt <= nt + tick;
  ffs_host_model host (.clk(clk), .clear_bits(cb), .fault_clear(fc), .frame_good(fg));
  ffs_supervisor dut (.clk(clk), .rst(rst), .sleep_mode(slp), .normal_mode(nrm),
    .temp_hot(hot), .temp_warm(warm), .current_high(cur), .load_open(lop),
    .ol_request(olr), .out1_gnd_short(sc[0]), .out2_gnd_short(sc[1]),
    .out1_supply_short(sc[2]), .out2_supply_short(sc[3]), .supply_high(shi),
    .supply_low(slo), .pump_low(pmp), .frame_bad(bad), .frame_good(fg),
    .clear_bits(cb), .fault_clear(fc), .output_off_pin(off_pin), .wake_pin(wake),
    .overtemp_flag(fl[0]), .temp_warning_flag(fl[1]), .overcurrent_flag(fl[2]),
    .open_load_flag(fl[3]), .out1_gnd_short_flag(fl[4]), .out2_gnd_short_flag(fl[5]),
    .out1_supply_short_flag(fl[6]), .out2_supply_short_flag(fl[7]),
    .supply_high_flag(fl[8]), .supply_low_flag(fl[9]), .pump_low_flag(fl[10]),
    .link_error_flag(fl[11]), .outputs_off(off), .freewheel_high(fwh),
    .fault_pin_n(fpn), .osc_tick(tick));
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input string nm, input logic e, input logic s);
    n_tests++;
    if (s !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, s);
    end
  endtask
  // warning is present whenever the die is warm and the part is awake
  function automatic logic exp_tw(input logic w, input logic s);
    return w && !s;
  endfunction
  // bounded wait on one flag, the check after it decides
  task automatic wfl(input int i, input logic v, input int lim);
    int k;
    k = 0;
    while (fl[i] !== v && k < lim)
    begin
      @(posedge clk);
      k++;
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    #(20 * 30000);
    error_cnt++;
    test_done();
  end
  initial
  begin
    void'($urandom(32'h504947FF));
    tk(10);
    rst <= 1'h0;
    nrm <= 1'h1;
    tk(2);
    nt0 = nt;
    tk(1000);
    chk("tick rate", 1'h1, (nt - nt0) >= 120 && (nt - nt0) <= 260);
    $display("end tick");
    for (int i = 0; i < 4; i++)
    begin
      sc <= 4'h1 << i;
      tk(2);
      chk("short flag", 1'h1, fl[4+i]);
      chk("outputs off", 1'h1, off);
      chk("fault pin", 1'h0, fpn);
      sc <= 4'h0;
      tk($urandom_range(2, 20));
      chk("short held", 1'h1, fl[4+i]);
      chk("still off", 1'h1, off);
      if (i < 2)
      begin
        // a wake or off pin toggle releases the outputs but leaves the flag
        if (i == 0)
          wake <= 1'h0;
        else
          off_pin <= 1'h1;
        tk(1);
        wake <= 1'h1;
        off_pin <= 1'h0;
        tk(2);
        chk("pin toggle release", 1'h0, off);
        chk("flag kept", 1'h1, fl[4+i]);
      end
      host.clear(10'h001 << (CB_SG1 + i));
      tk(2);
      chk("short clr", 1'h0, fl[4+i]);
      chk("released", 1'h0, off);
      chk("pin high", 1'h1, fpn);
    end
    $display("end shorts");
    cur <= 1'h1;
    tk(2);
    chk("oc flag", 1'h1, fl[2]);
    chk("oc no off", 1'h0, off);
    cur <= 1'h0;
    tk(3);
    chk("oc held", 1'h1, fl[2]);
    host.clear(10'h001 << CB_OC);
    tk(2);
    chk("oc clr", 1'h0, fl[2]);
    warm <= 1'h1;
    tk(1);
    chk("tw on", 1'h1, fl[1]);
    slp <= 1'h1;
    nrm <= 1'h0;
    tk(1);
    chk("tw sleep", 1'h0, fl[1]);
    repeat (40)
    begin
      warm <= 1'($urandom);
      slp <= 1'($urandom);
      tk(1);
      chk("tw random", exp_tw(warm, slp), fl[1]);
    end
    slp <= 1'h0;
    warm <= 1'h0;
    tk(1);
    chk("tw gone", 1'h0, fl[1]);
    lop <= 1'h1;
    nrm <= 1'h1;
    tk(3);
    chk("ol entry", 1'h1, fl[3]);
    host.clear(10'h001 << CB_OL);
    tk(2);
    chk("ol no req", 1'h0, fl[3]);
    olr <= 1'h1;
    tk(2);
    chk("ol req", 1'h1, fl[3]);
    olr <= 1'h0;
    lop <= 1'h0;
    host.clear(10'h001 << CB_OL);
    tk(2);
    chk("ol clr", 1'h0, fl[3]);
    $display("end status");
    slo <= 1'h1;
    tk(2);
    chk("uv flag", 1'h1, fl[9]);
    chk("uv off", 1'h1, off);
    slo <= 1'h0;
    tk(2);
    chk("uv resume", 1'h0, off);
    chk("uv held", 1'h1, fl[9]);
    chk("uv pin", 1'h0, fpn);
    host.clear(10'h001 << CB_UV);
    tk(2);
    chk("uv pin clr", 1'h1, fpn);
    shi <= 1'h1;
    wfl(8, 1'h1, 400);
    chk("ov flag", 1'h1, fl[8]);
    tk(2);
    chk("ov freewheel", 1'h1, fwh);
    chk("ov pin low", 1'h0, fpn);
    shi <= 1'h0;
    tk(300);
    chk("ov recover", 1'h0, fwh);
    chk("ov held", 1'h1, fl[8]);
    chk("ov pin", 1'h0, fpn);
    host.clear(10'h001 << CB_OV | 10'h001 << CB_UV);
    tk(2);
    chk("ov clr", 1'h0, fl[8]);
    chk("uv clr", 1'h0, fl[9]);
    hot <= 1'h1;
    wfl(0, 1'h1, 1200);
    chk("ot flag", 1'h1, fl[0]);
    chk("ot off", 1'h1, off);
    hot <= 1'h0;
    // filter output lags the input by an edge; a clear before that loses to set
    tk(2);
    host.clear(10'h001 << CB_OT);
    tk(2);
    chk("ot clr", 1'h0, fl[0]);
    chk("ot release", 1'h0, off);
    $display("end supply");
    pmp <= 1'h1;
    tk(PUMP_FILT_CYC);
    chk("pump early", 1'h0, fl[10]);
    wfl(10, 1'h1, 1000);
    chk("pump flag", 1'h1, fl[10]);
    chk("pump no off", 1'h0, off);
    pmp <= 1'h0;
    wfl(10, 1'h0, 1000);
    chk("pump gone", 1'h0, fl[10]);
    bad <= 1'h1;
    tk(1);
    bad <= 1'h0;
    tk(2);
    chk("link flag", 1'h1, fl[11]);
    chk("link hold", 1'h1, off);
    host.clear(10'h001 << CB_LNK);
    tk(2);
    chk("link clr", 1'h0, fl[11]);
    chk("link restart", 1'h0, off);
    $display("end pump link");
    sc <= 4'h2;
    tk(2);
    chk("pre reset", 1'h1, fl[5]);
    rst <= 1'h1;
    sc <= 4'h0;
    tk(2);
    chk("reset flags", 1'h1, fl == 12'h000);
    chk("reset off", 1'h0, off);
    chk("reset pin", 1'h1, fpn);
    rst <= 1'h0;
    tk(2);
    chk("after reset", 1'h0, off);
    chk("after reset pin", 1'h1, fpn);
    $display("end reset");
    test_done();
  end
endmodule
